/* File: dic_irq_conv.v */
`include "dic_consts.vh"
module dic_irq_conv (
   input  wire        mclk_i,
   input  wire        rstn_i,
   input  wire        ce_i,
   input  wire [1:0]  reg_addr_i,
   input  wire        reg_wr_i,
   input  wire        reg_rd_i,
   input  wire [15:0] reg_wdata_i,
   output reg  [15:0] reg_rdata_o,
   input  wire        host_doorbell_control_i,
   input  wire        host_ack_i,
   input  wire        host_instr_tick_i,
   output reg         host_doorbell_request_o,
   output wire        doorbell_request_flag_o,
   input  wire        external_port_pin_i,
   input  wire        adc_done_i,
   input  wire [7:0]  adc_data_i,
   input  wire        in_service_i,
   output reg         adc_start_o,
   output reg         adc_enable_o,
   output reg  [9:0]  dac_data_o,
   output reg         dac_load_o,
   output reg         user_output_a_o,
   output reg         user_output_b_o,
   output reg         priority_line_high_o,
   output reg         priority_line_mid_o,
   output reg         priority_line_low_o
);
   reg        doorbell_request_flag_r;
   reg        adc_request_flag_r;
   reg        dac_request_flag_r;
   reg        line2_mask_r;
   reg        line1_mask_r;
   reg        line0_mask_r;
   reg        global_irq_enable_r;
   reg [2:0]  route_r;
   reg [15:0] acr_r;
   reg        done_r;
   reg [7:0]  adc_res_r;
   reg [1:0]  ack_cnt_r;
   reg        ack_pend_r;
   reg        pin_q_r;
   wire       wr_icr;
   wire       wr_acr;
   wire       rd_data;
   wire       dac_tick;
   wire       adc_tick;
   wire       pin_rise;
   wire       dac_set;
   reg        db_line;
   reg        adc_line;
   reg        dac_line;
   reg        hi_req;
   reg        mid_req;
   reg        lo_req;

   assign wr_icr  = reg_wr_i && (reg_addr_i == `DIC_ADDR_ICR);
   assign wr_acr  = reg_wr_i && (reg_addr_i == `DIC_ADDR_ACR);
   assign rd_data = reg_rd_i && (reg_addr_i == `DIC_ADDR_DATA);
   assign doorbell_request_flag_o = doorbell_request_flag_r;

   dic_rate_timer u_dac_tmr (
      .mclk_i   (mclk_i),
      .rstn_i   (rstn_i),
      .ce_i     (ce_i),
      .period_i (acr_r[`DIC_B_DAC_RATE] ? `DIC_DAC_P10K : `DIC_DAC_P16K), // [R14]
      .tick_o   (dac_tick)
   );
   dic_rate_timer u_adc_tmr (
      .mclk_i   (mclk_i),
      .rstn_i   (rstn_i),
      .ce_i     (ce_i),
      .period_i (acr_r[`DIC_B_ADC_RATE] ? `DIC_ADC_P16K : `DIC_ADC_P8K), // [R19]
      .tick_o   (adc_tick)
   );

   assign pin_rise = external_port_pin_i && !pin_q_r;
   assign dac_set  = acr_r[`DIC_B_SRC_PIN] ? pin_rise : dac_tick; // [R13] [R3]

   // flags: a set in the same cycle as a clear wins
   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         doorbell_request_flag_r <= 1'b0;
         adc_request_flag_r      <= 1'b0;
         dac_request_flag_r      <= 1'b0;
         line2_mask_r            <= 1'b0;
         line1_mask_r            <= 1'b0;
         line0_mask_r            <= 1'b0;
         global_irq_enable_r     <= 1'b0; // [R9]
         route_r                 <= 3'b000;
         pin_q_r                 <= 1'b0;
      end else if (ce_i) begin
         pin_q_r <= external_port_pin_i;
         if (host_doorbell_control_i)
            doorbell_request_flag_r <= 1'b1; // [R1]
         else if (wr_icr && reg_wdata_i[`DIC_B_CLR_DB])
            doorbell_request_flag_r <= 1'b0; // [R4]
         if (adc_done_i)
            adc_request_flag_r <= 1'b1; // [R2]
         else if (wr_icr && reg_wdata_i[`DIC_B_CLR_ADC])
            adc_request_flag_r <= 1'b0; // [R4]
         if (dac_set)
            dac_request_flag_r <= 1'b1; // [R3]
         else if (wr_icr && reg_wdata_i[`DIC_B_CLR_DAC])
            dac_request_flag_r <= 1'b0; // [R4]
         if (wr_icr) begin
            line2_mask_r        <= reg_wdata_i[`DIC_B_MASK2]; // [R5]
            line1_mask_r        <= reg_wdata_i[`DIC_B_MASK1];
            line0_mask_r        <= reg_wdata_i[`DIC_B_MASK0];
            global_irq_enable_r <= reg_wdata_i[`DIC_B_GIE]; // [R9]
            route_r <= reg_wdata_i[`DIC_F_ROUTE_HI:`DIC_F_ROUTE_LO]; // [R10]
         end
      end
   end

   // host request: set by processor write, dropped three host instructions after ack
   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         host_doorbell_request_o <= 1'b0;
         ack_pend_r              <= 1'b0;
         ack_cnt_r               <= 2'd0;
      end else if (ce_i) begin
         if (host_ack_i) begin // [R7]
            ack_pend_r <= 1'b1;
            ack_cnt_r  <= 2'd0;
         end else if (ack_pend_r && host_instr_tick_i) begin
            if (ack_cnt_r == `DIC_ACK_DELAY - 2'd1) begin
               ack_pend_r <= 1'b0;
            end
            ack_cnt_r <= ack_cnt_r + 2'd1;
         end
         if (wr_icr && reg_wdata_i[`DIC_B_HOST_IRQ])
            host_doorbell_request_o <= 1'b1; // [R6]
         else if (ack_pend_r && host_instr_tick_i && !host_ack_i
                  && ack_cnt_r == `DIC_ACK_DELAY - 2'd1)
            host_doorbell_request_o <= 1'b0; // [R8]
      end
   end

   // converter control and data
   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         acr_r           <= `DIC_ACR_RST;
         done_r          <= 1'b0;
         adc_res_r       <= 8'h00;
         dac_data_o      <= 10'h000;
         dac_load_o      <= 1'b0;
         adc_start_o     <= 1'b0;
         adc_enable_o    <= 1'b0; // [R16]
         user_output_a_o <= 1'b0;
         user_output_b_o <= 1'b0;
      end else if (ce_i) begin
         dac_load_o <= 1'b0;
         if (reg_wr_i && reg_addr_i == `DIC_ADDR_DATA) begin
            dac_data_o <= reg_wdata_i[`DIC_DAC_W-1:0]; // [R11]
            dac_load_o <= 1'b1;
         end
         if (wr_acr) begin
            acr_r <= reg_wdata_i;
            adc_enable_o    <= reg_wdata_i[`DIC_B_ADC_EN]; // [R16]
            user_output_a_o <= reg_wdata_i[`DIC_B_USER_A]; // [R15]
            user_output_b_o <= reg_wdata_i[`DIC_B_USER_B]; // [R15]
         end
         // start pulse: explicit trigger, or timer tick otherwise; an enable written
         // together with the start bit must count, or the first trigger is lost
         adc_start_o <= (wr_acr ? reg_wdata_i[`DIC_B_ADC_EN] : adc_enable_o) &&
                        ((wr_acr && reg_wdata_i[`DIC_B_START]) || // [R18]
                         (!acr_r[`DIC_B_START] && adc_tick));
         if (adc_done_i) begin
            adc_res_r <= adc_data_i;
            done_r    <= 1'b1; // [R17]
         end else if (rd_data)
            done_r <= 1'b0; // [R17]
      end
   end

   // routing: columns doorbell, adc, dac
   always @* begin
      db_line  = 1'b0;
      adc_line = 1'b0;
      dac_line = 1'b0;
      hi_req   = 1'b0;
      mid_req  = 1'b0;
      lo_req   = 1'b0;
      case (route_r) // [R10] [R21]
         3'b000: begin
            hi_req  = doorbell_request_flag_r;
            mid_req = adc_request_flag_r;
            lo_req  = dac_request_flag_r;
         end
         3'b001: begin
            mid_req = doorbell_request_flag_r;
            hi_req  = adc_request_flag_r;
            lo_req  = dac_request_flag_r;
         end
         3'b010: begin
            hi_req  = doorbell_request_flag_r;
            lo_req  = adc_request_flag_r;
            mid_req = dac_request_flag_r;
         end
         3'b011: begin
            mid_req = doorbell_request_flag_r;
            lo_req  = adc_request_flag_r;
            hi_req  = dac_request_flag_r;
         end
         3'b100: begin
            lo_req  = doorbell_request_flag_r;
            hi_req  = adc_request_flag_r;
            mid_req = dac_request_flag_r;
         end
         3'b101: begin
            lo_req  = doorbell_request_flag_r;
            mid_req = adc_request_flag_r;
            hi_req  = dac_request_flag_r;
         end
         default: begin
            // reserved codes route nothing
            db_line = 1'b0;
         end
      endcase
      adc_line = hi_req && line2_mask_r && global_irq_enable_r; // [R22] [R5]
      db_line  = mid_req && line1_mask_r && global_irq_enable_r; // [R22]
      dac_line = lo_req && line0_mask_r && global_irq_enable_r; // [R22]
   end

   // one line at a time, highest first, held off while a routine runs
   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         priority_line_high_o <= 1'b0;
         priority_line_mid_o  <= 1'b0;
         priority_line_low_o  <= 1'b0;
      end else if (ce_i) begin
         priority_line_high_o <= !in_service_i && adc_line; // [R20]
         priority_line_mid_o  <= !in_service_i && !adc_line && db_line; // [R20]
         priority_line_low_o  <= !in_service_i && !adc_line && !db_line && dac_line;
      end
   end

   // read mux; clear bits, host bit and reserved bits read zero; control register bit 9 reads one
   always @* begin
      reg_rdata_o = 16'h0000;
      case (reg_addr_i)
         `DIC_ADDR_ICR: begin
            reg_rdata_o[`DIC_B_DB_FLAG]  = doorbell_request_flag_r; // [R1]
            reg_rdata_o[`DIC_B_ADC_FLAG] = adc_request_flag_r;
            reg_rdata_o[`DIC_B_DAC_FLAG] = dac_request_flag_r;
            reg_rdata_o[`DIC_B_MASK2]    = line2_mask_r;
            reg_rdata_o[`DIC_B_MASK1]    = line1_mask_r;
            reg_rdata_o[`DIC_B_MASK0]    = line0_mask_r;
            reg_rdata_o[`DIC_B_GIE]      = global_irq_enable_r;
            reg_rdata_o[`DIC_F_ROUTE_HI:`DIC_F_ROUTE_LO] = route_r; // [R4] [R23]
         end
         `DIC_ADDR_DATA: begin
            reg_rdata_o[`DIC_ADC_HI:`DIC_ADC_LO] = adc_res_r; // [R12]
         end
         `DIC_ADDR_ACR: begin
            reg_rdata_o[`DIC_B_SRC_PIN]  = acr_r[`DIC_B_SRC_PIN];
            reg_rdata_o[`DIC_B_ACR_ONE]  = 1'b1;
            reg_rdata_o[`DIC_B_DAC_RATE] = acr_r[`DIC_B_DAC_RATE];
            reg_rdata_o[`DIC_B_USER_B]   = acr_r[`DIC_B_USER_B];
            reg_rdata_o[`DIC_B_USER_A]   = acr_r[`DIC_B_USER_A];
            reg_rdata_o[`DIC_B_ADC_EN]   = adc_enable_o;
            reg_rdata_o[`DIC_B_DONE]     = done_r; // [R17]
            reg_rdata_o[`DIC_B_START]    = acr_r[`DIC_B_START];
            reg_rdata_o[`DIC_B_CLK_SEL]  = acr_r[`DIC_B_CLK_SEL];
            reg_rdata_o[`DIC_B_ADC_RATE] = acr_r[`DIC_B_ADC_RATE];
         end
         default: begin
            reg_rdata_o = 16'h0000;
         end
      endcase
   end
endmodule // dic_irq_conv

/* File: dic_consts.vh */
// Functional notes
// (R1) doorbell flag set only by host control write; cleared by writing its clear bit.
// (R2) adc flag set when conversion result lands; cleared by its clear bit.
// (R3) dac flag set by dac timer tick; cleared by its clear bit.
// (R4) clear bits 4,3,2 clear flags on one, ignore zero, read zero.
// (R5) per-line mask bits: one lets the line through, zero blocks it.
// (R6) host interrupt bit unstored; processor write of one raises host request.
// (R7) host acknowledges by writing one to bit 0 of its control register.
// (R8) host request drops three host instruction times after acknowledge.
// (R9) global enable gates all lines; reset forces it off.
// (R10) routing field places the three flags on lines per table; 110/111 reserved.
// (R11) data write loads ten dac bits, upper six ignored.
// (R12) data read returns adc result in bits 9..2, bits 1..0 zero.
// (R13) control bit 15 selects dac flag source: pin or dac timer.
// (R14) control bit 8 selects dac timer period.
// (R15) control bits 6 and 7 drive two user output pins.
// (R16) control bit 5 enables the adc; reset forces zero.
// (R17) bit 4 is read-only conversion complete, cleared by data read.
// (R18) writing bit 3 starts one conversion; else conversions wait for timer.
// (R19) control bit 0 selects adc timer period.
// (R20) pending lines served high first; no nesting.
// (R21) table columns: doorbell, adc, dac; code 000 gives high, mid, low.
// (R22) line asserted only if routed flag set, mask one, global enable one.
// (R23) interrupt control bits 1 and 0 ignore writes, read zero.
`ifndef DIC_CONSTS_VH
`define DIC_CONSTS_VH
`define DIC_ADDR_ICR      2'b00
`define DIC_ADDR_DATA     2'b01
`define DIC_ADDR_ACR      2'b10
`define DIC_B_DB_FLAG     15
`define DIC_B_ADC_FLAG    14
`define DIC_B_DAC_FLAG    13
`define DIC_B_MASK2       12
`define DIC_B_MASK1       11
`define DIC_B_MASK0       10
`define DIC_B_HOST_IRQ    9
`define DIC_B_GIE         8
`define DIC_F_ROUTE_HI    7
`define DIC_F_ROUTE_LO    5
`define DIC_B_CLR_DB      4
`define DIC_B_CLR_ADC     3
`define DIC_B_CLR_DAC     2
`define DIC_B_SRC_PIN     15
`define DIC_B_ACR_ONE     9
`define DIC_B_DAC_RATE    8
`define DIC_B_USER_B      7
`define DIC_B_USER_A      6
`define DIC_B_ADC_EN      5
`define DIC_B_DONE        4
`define DIC_B_START       3
`define DIC_B_CLK_SEL     1
`define DIC_B_ADC_RATE    0
`define DIC_DAC_W         10
`define DIC_ADC_LO        2
`define DIC_ADC_HI        9
`define DIC_ACR_RST       16'h0002
`define DIC_ACK_DELAY     2'h3
`define DIC_DAC_P16K      20'h0_1e84
`define DIC_DAC_P10K      20'h0_30d4
`define DIC_ADC_P16K      20'h0_1e84
`define DIC_ADC_P8K       20'h0_3d09
`define DIC_CONV_CYC      20'h0_0014
`endif

/* File: dic_rate_timer.v */
`include "dic_consts.vh"
module dic_rate_timer (
   input  wire        mclk_i,
   input  wire        rstn_i,
   input  wire        ce_i,
   input  wire [19:0] period_i,
   output reg         tick_o
);
   reg [19:0] cnt_r;
   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_r  <= 20'h0_0000;
         tick_o <= 1'b0;
      end else if (ce_i) begin
         // free running; a period change applies to the lap in progress, wrapping at once if the count is already past it
         if (cnt_r >= period_i - 20'h0_0001) begin
            cnt_r  <= 20'h0_0000;
            tick_o <= 1'b1;
         end else begin
            cnt_r  <= cnt_r + 20'h0_0001;
            tick_o <= 1'b0;
         end
      end
   end
endmodule // dic_rate_timer

/* File: dic_irq_conv_chk.sv */
module dic_irq_conv_chk (
   input wire logic        mclk_i,
   input wire logic        rstn_i,
   input wire logic        ce_i,
   input wire logic [1:0]  reg_addr_i,
   input wire logic        reg_wr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic [15:0] reg_rdata_o,
   input wire logic        host_doorbell_control_i,
   input wire logic        host_doorbell_request_o,
   input wire logic        doorbell_request_flag_o,
   input wire logic        in_service_i,
   input wire logic        adc_start_o,
   input wire logic        adc_enable_o,
   input wire logic [9:0]  dac_data_o,
   input wire logic        dac_load_o,
   input wire logic        user_output_a_o,
   input wire logic        user_output_b_o,
   input wire logic        priority_line_high_o,
   input wire logic        priority_line_mid_o,
   input wire logic        priority_line_low_o
);
   timeunit 1ns;
   timeprecision 100ps;
   wire       wr_c  = reg_wr_i & ce_i;
   wire       clr_b = wr_c && reg_addr_i == 2'b00 && reg_wdata_i[4];
   wire [2:0] lines = {priority_line_high_o, priority_line_mid_o, priority_line_low_o};
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   a_one_line: assert property ($onehot0(lines))
      else $error("more than one priority line high");
   // lines are registered, so suppression is only demanded from the second cycle
   a_no_nesting: assert property (in_service_i && $past(in_service_i) && $past(ce_i)
      |-> lines == 3'b000) else $error("line raised during service");
   a_ctl_zero_bits: assert property (reg_addr_i == 2'b00 |-> reg_rdata_o[9] == 1'b0
      && reg_rdata_o[4:0] == 5'h00) else $error("unstored control bits read nonzero");
   a_data_pad: assert property (reg_addr_i == 2'b01 |-> reg_rdata_o[1:0] == 2'b00)
      else $error("converter data padding nonzero");
   a_dac_load: assert property (wr_c && reg_addr_i == 2'b01 |=> dac_load_o
      && dac_data_o == $past(reg_wdata_i[9:0])) else $error("dac word not loaded");
   a_mode_pins: assert property (wr_c && reg_addr_i == 2'b10 |=>
      {user_output_b_o, user_output_a_o, adc_enable_o} == $past(reg_wdata_i[7:5]))
      else $error("mode pins do not follow write");
   a_start_once: assert property (wr_c && reg_addr_i == 2'b10 && reg_wdata_i[5]
      && reg_wdata_i[3] |=> adc_start_o ##1 !adc_start_o) else $error("start pulse wrong");
   a_host_raise: assert property (wr_c && reg_addr_i == 2'b00 && reg_wdata_i[9]
      |=> host_doorbell_request_o) else $error("host request not raised");
   a_bell_set: assert property (host_doorbell_control_i && ce_i |=> doorbell_request_flag_o)
      else $error("doorbell flag not set");
   a_bell_clear: assert property (clr_b && !host_doorbell_control_i
      |=> !doorbell_request_flag_o) else $error("doorbell flag not cleared");
   a_bell_holds: assert property (doorbell_request_flag_o && !clr_b
      |=> doorbell_request_flag_o) else $error("doorbell flag lost");
   cover property (host_doorbell_request_o ##1 !host_doorbell_request_o);
   cover property (adc_start_o);
   cover property (priority_line_high_o && doorbell_request_flag_o);
endmodule // dic_irq_conv_chk

bind dic_irq_conv dic_irq_conv_chk i_dic_irq_conv_chk (
   .mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
   .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
   .host_doorbell_control_i(host_doorbell_control_i),
   .host_doorbell_request_o(host_doorbell_request_o),
   .doorbell_request_flag_o(doorbell_request_flag_o), .in_service_i(in_service_i),
   .adc_start_o(adc_start_o), .adc_enable_o(adc_enable_o), .dac_data_o(dac_data_o),
   .dac_load_o(dac_load_o), .user_output_a_o(user_output_a_o),
   .user_output_b_o(user_output_b_o), .priority_line_high_o(priority_line_high_o),
   .priority_line_mid_o(priority_line_mid_o), .priority_line_low_o(priority_line_low_o));

/* File: dic_far_model.sv */
module dic_far_model (
   input  wire logic       mclk_i,
   input  wire logic       rstn_i,
   input  wire logic       adc_start_i,
   input  wire logic       slow_i,
   input  wire logic [7:0] adc_val_i,
   input  wire logic       ack_req_i,
   output logic            adc_done_o,
   output logic [7:0]      adc_data_o,
   output logic            host_ack_o,
   output logic            host_tick_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] cnt_r, wait_r;
   logic       busy_r, ack_r;
   // outside the done pulse the result lines wander, so a late capture shows
   assign adc_data_o  = adc_done_o ? adc_val_i : cnt_r;
   assign host_tick_o = (cnt_r[1:0] == 2'b11);
   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         {cnt_r, wait_r, busy_r, ack_r, adc_done_o, host_ack_o} <= '0;
      end else begin
         cnt_r      <= cnt_r + 8'h01;
         adc_done_o <= 1'b0;
         host_ack_o <= 1'b0;
         if (adc_start_i) begin
            busy_r <= 1'b1;
            wait_r <= slow_i ? 8'd40 : 8'd2;
         end else if (busy_r) begin
            wait_r <= wait_r - 8'd1;
            if (wait_r == 8'd0) begin
               busy_r     <= 1'b0;
               adc_done_o <= 1'b1;
            end
         end
         if (ack_req_i) begin
            ack_r <= 1'b1;
         end
         // acknowledge lands between instruction ticks, as a host store would
         if (ack_r && cnt_r[1:0] == 2'b00) begin
            ack_r      <= 1'b0;
            host_ack_o <= 1'b1;
         end
      end
   end
endmodule // dic_far_model

/* File: tb_top.sv */
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic        mclk, rstn, ce, wen, rd, bell, pin, insvc, slow, ack_req;
   logic        ack, tick, hreq, bflag, done, start, aen, dload, ua, ub, lh, lm, ll;
   logic [1:0]  addr;
   logic [15:0] wdata, rdata;
   logic [7:0]  aval, adata;
   logic [9:0]  dac;
   int          errors, samples_checked, i, k, n;
   int          ln [3][6] = '{'{2, 1, 2, 1, 0, 0}, '{1, 2, 0, 0, 2, 1}, '{0, 0, 1, 2, 1, 2}};

   dic_irq_conv i_dic_irq_conv (
      .mclk_i(mclk), .rstn_i(rstn), .ce_i(ce), .reg_addr_i(addr), .reg_wr_i(wen),
      .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
      .host_doorbell_control_i(bell), .host_ack_i(ack), .host_instr_tick_i(tick),
      .host_doorbell_request_o(hreq), .doorbell_request_flag_o(bflag),
      .external_port_pin_i(pin), .adc_done_i(done), .adc_data_i(adata), .in_service_i(insvc),
      .adc_start_o(start), .adc_enable_o(aen), .dac_data_o(dac), .dac_load_o(dload),
      .user_output_a_o(ua), .user_output_b_o(ub), .priority_line_high_o(lh),
      .priority_line_mid_o(lm), .priority_line_low_o(ll));
   dic_far_model i_dic_far_model (
      .mclk_i(mclk), .rstn_i(rstn), .adc_start_i(start), .slow_i(slow), .adc_val_i(aval),
      .ack_req_i(ack_req), .adc_done_o(done), .adc_data_o(adata), .host_ack_o(ack),
      .host_tick_o(tick));

   task automatic chk(input bit ok, input string m);
      samples_checked++;
      if (!ok) begin
         errors++;
         $display("wrong value at %0t ns: %s", $time, m);
      end
   endtask
   task automatic tmo(input int cnt, input int lim);
      if (cnt >= lim) begin
         errors++;
         $display("wrong value at %0t ns: wait ran out", $time);
         wrap_up();
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge mclk);
      #1 {addr, wdata, wen} = {a, d, 1'b1};
      @(posedge mclk);
      #1 wen = 1'b0;
   endtask
   task automatic rdx(input logic [1:0] a, input logic [15:0] m, input logic [15:0] e);
      @(posedge mclk);
      #1 {addr, rd} = {a, 1'b1};
      #2 chk((rdata & m) === e, "register read");
      @(posedge mclk);
      #1 rd = 1'b0;
   endtask
   task automatic lines(input logic [2:0] e);
      repeat (2) @(posedge mclk);
      #1 chk({lh, lm, ll} === e, "priority lines");
   endtask
   task automatic route(input int s);
      for (int c = 0; c < 8; c++) begin
         wr(2'b00, 16'h1d00 | 16'(c << 5));
         lines((c < 6) ? (3'b001 << ln[s][c]) : 3'b000);
         if (c < 6) begin
            wr(2'b00, (16'h1d00 & ~(16'h0400 << ln[s][c])) | 16'(c << 5));
            lines(3'b000);
         end
      end
      wr(2'b00, 16'h1c00);
      lines(3'b000);
      wr(2'b00, 16'h1d00);
      insvc = 1'b1;
      lines(3'b000);
      insvc = 1'b0;
   endtask
   task automatic gap(input int p);
      for (int j = 0; j < 2; j++) begin
         wr(2'b00, 16'h1d04);
         @(posedge mclk);
         #1 n = 0;
         while (ll !== 1'b1 && n < 13000) begin
            @(posedge mclk);
            #1 n++;
         end
         tmo(n, 13000);
      end
      // the first lap only aligns to the free-running timer
      chk(n + 3 >= p - 1 && n + 3 <= p + 1, "dac tick period");
   endtask
   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   initial begin
      {rstn, wen, rd, bell, pin, insvc, slow, ack_req, addr, wdata, aval} = '0;
      ce = 1'b1;
      repeat (16) @(posedge mclk);
      #1 rstn = 1'b1;
      rdx(2'b10, 16'hffff, 16'h0202);
      rdx(2'b00, 16'he100, 16'h0000);
      rdx(2'b11, 16'hffff, 16'h0000);
      wr(2'b10, 16'h80c0);
      chk({ub, ua} === 2'b11, "user pins");
      for (i = 0; i < 2; i++) begin
         slow = i[0];
         aval = i[0] ? 8'h3c : 8'ha5;
         wr(2'b10, 16'h8028);
         n = 0;
         while (done !== 1'b1 && n < 60) begin
            @(posedge mclk);
            #1 n++;
         end
         tmo(n, 60);
         rdx(2'b10, 16'h0010, 16'h0010);
         rdx(2'b00, 16'h4000, 16'h4000);
         rdx(2'b01, 16'h03ff, {6'h00, aval, 2'b00});
         rdx(2'b10, 16'h0010, 16'h0000);
      end
      route(1);
      $display("test conversion done");
      bell = 1'b1;
      @(posedge mclk);
      #1 bell = 1'b0;
      chk(bflag === 1'b1, "doorbell flag");
      wr(2'b00, 16'h1d00);
      lines(3'b100);
      wr(2'b00, 16'h0008);
      rdx(2'b00, 16'hc000, 16'h8000);
      route(0);
      for (k = 0; k < 3; k++) begin
         pin = (k == 2);
         if (k == 2)
            route(2);
         wr(2'b00, 16'h0010 >> k);
         rdx(2'b00, 16'he000, 16'h0000);
      end
      $display("test routing done");
      wr(2'b10, 16'h0000);
      gap(7812);
      wr(2'b10, 16'h0100);
      gap(12500);
      $display("test dac timer done");
      wr(2'b00, 16'h0200);
      chk(hreq === 1'b1, "host request");
      rdx(2'b00, 16'h0200, 16'h0000);
      ack_req = 1'b1;
      @(posedge mclk);
      #1 {ack_req, n} = 0;
      while (ack !== 1'b1 && n < 20) begin
         @(posedge mclk);
         #1 n++;
      end
      tmo(n, 20);
      for (k = 0; k < 3; k++) begin
         n = 0;
         while (tick !== 1'b1 && n < 8) begin
            @(posedge mclk);
            #1 n++;
         end
         tmo(n, 8);
         chk(hreq === 1'b1, "host request dropped early");
         @(posedge mclk);
         #1;
      end
      chk(hreq === 1'b0, "host request still high");
      $display("test host doorbell done");
      wr(2'b01, 16'hfeb5);
      chk(dac === 10'h2b5, "dac data");
      wr(2'b10, 16'h0050);
      rdx(2'b10, 16'hfff7, 16'h0240);
      $display("test data and pins done");
      ce = 1'b0;
      wr(2'b10, 16'h0080);
      chk({ub, ua} === 2'b01, "frozen user pins");
      ce = 1'b1;
      wr(2'b10, 16'h0021);
      for (k = 0; k < 2; k++) begin
         n = 0;
         do begin
            @(posedge mclk);
            #1 n++;
         end while (done !== 1'b1 && n < 8000);
         tmo(n, 8000);
      end
      chk(n >= 7811 && n <= 7813, "adc timer period");
      $display("test adc timer done");
      wrap_up();
   end
endmodule // tb_top
